// ===== src/dcc_pkg.sv
package dcc_pkg;

  // ==========================================================================
  // Sizes of the block.
  localparam int NUM_CH     = 4;
  localparam int CH_W       = 2;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int DESC_NUM   = 8;
  localparam int DESC_IDX_W = 3;
  localparam int DESC_W     = 27;
  localparam int ATTR_NUM   = 4;

  // ==========================================================================
  // Register byte offsets.
  localparam logic [ADDR_W-1:0] REG_ENA_SET   = 8'h00;
  localparam logic [ADDR_W-1:0] REG_ENA_CLR   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_ATTR_GET  = 8'h08;
  localparam logic [ADDR_W-1:0] REG_ATTR_BASE = 8'h10;
  localparam logic [ADDR_W-1:0] REG_ATTR_STEP = 8'h08;
  localparam logic [ADDR_W-1:0] REG_CLR_OFS   = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PERIPH    = 8'h30;
  localparam logic [ADDR_W-1:0] REG_SWREQ     = 8'h34;
  localparam logic [ADDR_W-1:0] REG_DESC_BASE = 8'h40;

  // ==========================================================================
  // Attribute positions inside one channel's flag nibble.
  localparam int ATTR_BURST = 0;
  localparam int ATTR_ALT   = 1;
  localparam int ATTR_PRIO  = 2;
  localparam int ATTR_MASK  = 3;

  // ==========================================================================
  // Control word layout.
  localparam int SIZE_LSB = 0;
  localparam int SRC_LSB  = 2;
  localparam int DST_LSB  = 4;
  localparam int STEP_W   = 2;
  localparam int ARB_LSB  = 6;
  localparam int ARB_W    = 4;
  localparam int TAIL_BIT = 10;
  localparam int MODE_LSB = 11;
  localparam int MODE_W   = 3;
  localparam int CNT_LSB  = 16;
  localparam int CNT_W    = 11;

  localparam logic [STEP_W-1:0] SIZE_8        = 2'h0;
  localparam logic [STEP_W-1:0] SIZE_16       = 2'h1;
  localparam logic [STEP_W-1:0] SIZE_32       = 2'h2;
  localparam logic [STEP_W-1:0] SRC_STEP_NONE = 2'h3;
  localparam logic [STEP_W-1:0] DST_STEP_NONE = 2'h3;
  localparam logic [ARB_W-1:0]  ARB_SIZE_MAX  = 4'hA;
  localparam logic [CNT_W-1:0]  CNT_ONE       = 11'h001;
  localparam logic [CNT_W-1:0]  CNT_ZERO      = 11'h000;

  // ==========================================================================
  // Transfer modes and engine states.
  typedef enum logic [MODE_W-1:0] {
    MODE_STOP, MODE_BASIC, MODE_AUTO, MODE_PINGPONG, MODE_MEM_SG, MODE_PER_SG
  } dcc_mode_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_MOVE, ST_WB} dcc_state_t;

endpackage

// ===== src/dcc_desc_if.sv
`timescale 1ns/1ps
// ============================================================================
// Port of the control structure memory.
interface dcc_desc_if;
  import dcc_pkg::*;
  logic                  wrEn;
  logic [DESC_IDX_W-1:0] wrAddr;
  logic [DESC_W-1:0]     wrData;
  logic [DESC_IDX_W-1:0] rdAddr;
  logic [DESC_W-1:0]     rdData;

  modport ctrl (output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem  (input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface

// ===== src/dcc_desc_mem.sv
`timescale 1ns/1ps
// ============================================================================
// Control structure store: one primary and one alternate word per channel.
module dcc_desc_mem
  import dcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  dcc_desc_if.mem  port
);

  logic [DESC_W-1:0] store [DESC_NUM];

  // The array has no reset; software programs a word before enabling its channel.
  always_ff @(posedge clk) begin
    if (port.wrEn) begin
      store[port.wrAddr] <= port.wrData;
    end
  end

  // Registered read, so data appear in the cycle after the address.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      port.rdData <= '0;
    end else begin
      port.rdData <= store[port.rdAddr];
    end
  end

endmodule

// ===== src/dcc_channel_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - A channel moves no item unless its enable is set.
// - Hardware clears a channel's enable when its transfer completes.
// - Requests on a disabled channel are ignored until it is enabled again.
// - Software reads each channel's enable state.
// - Burst-only channels ignore single requests.
// - Alternate-structure attribute makes the alternate word the active descriptor.
// - High-priority channels win arbitration over normal ones.
// - Request-mask attribute hides the peripheral request line.
// - Attributes set and clear individually; all read together as flags.
// - Control word selects item size of 8, 16 or 32 bits.
// - Control word selects source step: byte, halfword, word or none.
// - Control word selects destination step independently, same choices.
// - Arbitration size, 1 to 1024 items, bounds items per bus tenure.
// - Tail burst flag accepts only bursts in the final partial tenure.
// - Primary and alternate control words are programmed separately.
// - Each channel selects which peripheral's request lines drive it.
// - Basic mode moves only while requested, pausing when request drops.
// - Auto mode completes all items once started by one request.
// - Remaining count is readable, decrements per item, reads zero when done.
// - Mode field reads stopped once the transfer completes.
module dcc_channel_ctrl
  import dcc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdData,
  input  wire logic [NUM_CH-1:0] priSingleReq,
  input  wire logic [NUM_CH-1:0] priBurstReq,
  input  wire logic [NUM_CH-1:0] secSingleReq,
  input  wire logic [NUM_CH-1:0] secBurstReq,
  output logic                   busReq,
  input  wire logic              busDone,
  output logic      [CH_W-1:0]   busChan,
  output logic                   busAltStruct,
  output logic      [STEP_W-1:0] busItemSize,
  output logic      [STEP_W-1:0] busSrcStep,
  output logic      [STEP_W-1:0] busDstStep,
  output logic      [NUM_CH-1:0] chanDone
);

  // ==========================================================================
  // Helpers.
  function automatic logic hit(input logic strobe, input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    return strobe && (a == off);
  endfunction

  function automatic logic isDesc(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1:DESC_IDX_W+2] == REG_DESC_BASE[ADDR_W-1:DESC_IDX_W+2];
  endfunction

  function automatic logic [NUM_CH-1:0] chanBit(input logic [CH_W-1:0] ch);
    logic [NUM_CH-1:0] r;
    r = '0;
    r[ch] = 1'b1;
    return r;
  endfunction

  // Lowest numbered set bit, with a valid flag on top.
  function automatic logic [CH_W:0] pickLowest(input logic [NUM_CH-1:0] v);
    logic [CH_W:0] r;
    r = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = {1'b1, CH_W'(i)};
      end
    end
    return r;
  endfunction

  // ==========================================================================
  // State.
  dcc_desc_if descIf ();

  logic [NUM_CH-1:0]     enable_q, enable_d, swReq_q, autoRun_q, periphSel_q, chanDone_q;
  logic [NUM_CH-1:0]     attr_q [ATTR_NUM];
  logic [NUM_CH-1:0]     swSet, swClr, hwClr, singleSel, burstSel, hwReq, eligible, hiElig;
  logic [NUM_CH*ATTR_NUM-1:0] attrFlags;
  dcc_state_t            state_q, state_d;
  logic [CH_W-1:0]       chan_q, winCh;
  logic [CH_W:0]         hiPick, anyPick;
  logic                  winValid, grant, finish, alt_q, run_q, actReq, tailZone, fetchTail;
  logic [DESC_W-1:0]     work_q;
  logic [CNT_W-1:0]      beats_q, workCnt, fetchCnt, arbLimit;
  logic                  swDescRd, swDescWr, rdMem_q;
  logic [DESC_IDX_W-1:0] regDescIdx;
  logic [DATA_W-1:0]     rdReg_q, rdNext;

  dcc_desc_mem u_mem (
    .clk   (clk),
    .rst_b (rst_b),
    .port  (descIf.mem)
  );

  // ==========================================================================
  // Register writes: enables, attributes, peripheral selection, soft requests.
  assign swSet = hit(regWr, regAddr, REG_ENA_SET) ? regWrData[NUM_CH-1:0] : '0;
  assign swClr = hit(regWr, regAddr, REG_ENA_CLR) ? regWrData[NUM_CH-1:0] : '0;
  assign hwClr = finish ? chanBit(chan_q) : '0;
  // A software enable in the same cycle as completion wins, so no arm is lost.
  assign enable_d = (enable_q & ~swClr & ~hwClr) | swSet;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enable_q <= '0;
    end else begin
      enable_q <= enable_d;
    end
  end

  // Each attribute has its own set and clear word, so others are untouched.
  for (genvar k = 0; k < ATTR_NUM; k++) begin : g_attr
    localparam logic [ADDR_W-1:0] SetOfs = ADDR_W'(REG_ATTR_BASE + k * REG_ATTR_STEP);
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        attr_q[k] <= '0;
      end else if (hit(regWr, regAddr, SetOfs)) begin
        attr_q[k] <= attr_q[k] | regWrData[NUM_CH-1:0];
      end else if (hit(regWr, regAddr, ADDR_W'(SetOfs + REG_CLR_OFS))) begin
        attr_q[k] <= attr_q[k] & ~regWrData[NUM_CH-1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      periphSel_q <= '0;
    end else if (hit(regWr, regAddr, REG_PERIPH)) begin
      periphSel_q <= regWrData[NUM_CH-1:0];
    end
  end

  // A soft request is held until the channel wins; a new write beats the clear.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      swReq_q <= '0;
    end else begin
      swReq_q <= (swReq_q & ~(grant ? chanBit(winCh) : '0))
               | (hit(regWr, regAddr, REG_SWREQ) ? regWrData[NUM_CH-1:0] : '0);
    end
  end

  // ==========================================================================
  // Request qualification per channel.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_req
    assign singleSel[c] = periphSel_q[c] ? secSingleReq[c] : priSingleReq[c];
    assign burstSel[c]  = periphSel_q[c] ? secBurstReq[c] : priBurstReq[c];
    assign hwReq[c]     = ~attr_q[ATTR_MASK][c]
                        & (burstSel[c] | (singleSel[c] & ~attr_q[ATTR_BURST][c]));
    assign eligible[c]  = enable_q[c] & (hwReq[c] | swReq_q[c] | autoRun_q[c]);
    for (genvar k = 0; k < ATTR_NUM; k++) begin : g_flag
      assign attrFlags[c*ATTR_NUM+k] = attr_q[k][c];
    end
  end

  // High-priority channels are searched first.
  assign hiElig   = eligible & attr_q[ATTR_PRIO];
  assign hiPick   = pickLowest(hiElig);
  assign anyPick  = pickLowest(eligible);
  assign winValid = anyPick[CH_W];
  assign winCh    = hiPick[CH_W] ? hiPick[CH_W-1:0] : anyPick[CH_W-1:0];

  // ==========================================================================
  // Active descriptor fields.
  assign workCnt  = work_q[CNT_LSB +: CNT_W];
  assign fetchCnt = descIf.rdData[CNT_LSB +: CNT_W];
  assign arbLimit = CNT_W'(CNT_ONE << work_q[ARB_LSB +: ARB_W]);
  // In the last partial tenure the tail flag narrows service to bursts.
  assign tailZone = work_q[TAIL_BIT] && (workCnt < arbLimit);
  assign actReq   = ~attr_q[ATTR_MASK][chan_q]
                  & (burstSel[chan_q]
                     | (singleSel[chan_q] & ~attr_q[ATTR_BURST][chan_q] & ~tailZone));
  assign fetchTail = descIf.rdData[TAIL_BIT] && !autoRun_q[chan_q]
                   && fetchCnt < CNT_W'(CNT_ONE << descIf.rdData[ARB_LSB +: ARB_W])
                   && !(burstSel[chan_q] && !attr_q[ATTR_MASK][chan_q]);

  // ==========================================================================
  // Engine sequencing.
  always_comb begin
    state_d = state_q;
    grant   = 1'b0;
    finish  = 1'b0;
    case (state_q)
      ST_IDLE: begin
        // A software descriptor read owns the memory port this cycle.
        if (winValid && !swDescRd) begin
          grant   = 1'b1;
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (!enable_q[chan_q]) begin
          state_d = ST_WB;
        end else if (fetchCnt == CNT_ZERO ||
                     descIf.rdData[MODE_LSB +: MODE_W] == MODE_STOP) begin
          finish  = 1'b1;
          state_d = ST_WB;
        end else if (fetchTail) begin
          state_d = ST_WB;
        end else begin
          state_d = ST_MOVE;
        end
      end
      ST_MOVE: begin
        if (busDone) begin
          if (workCnt == CNT_ONE) begin
            finish  = 1'b1;
            state_d = ST_WB;
          end else if (beats_q + CNT_ONE == arbLimit || !enable_q[chan_q] ||
                       (!run_q && !actReq)) begin
            state_d = ST_WB;
          end
        end
      end
      ST_WB: begin
        // A software descriptor write takes the port; write back next cycle.
        if (!swDescWr) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Grant latches channel and structure; alternate attribute picks the word.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_q <= '0;
      alt_q  <= 1'b0;
    end else if (grant) begin
      chan_q <= winCh;
      alt_q  <= attr_q[ATTR_ALT][winCh];
    end
  end

  // Auto runs keep a channel eligible after its request goes away.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      autoRun_q <= '0;
      run_q     <= 1'b0;
    end else begin
      if (state_q == ST_FETCH) begin
        run_q <= descIf.rdData[MODE_LSB +: MODE_W] == MODE_AUTO;
      end
      if (state_q == ST_FETCH && descIf.rdData[MODE_LSB +: MODE_W] == MODE_AUTO) begin
        autoRun_q <= (autoRun_q | chanBit(chan_q)) & enable_d;
      end else begin
        autoRun_q <= autoRun_q & enable_d & ~hwClr;
      end
    end
  end

  // Working copy of the descriptor: counts items and stops the mode.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      work_q  <= '0;
      beats_q <= '0;
    end else if (state_q == ST_FETCH) begin
      work_q  <= descIf.rdData;
      beats_q <= '0;
      if (finish) begin
        work_q[MODE_LSB +: MODE_W] <= MODE_STOP;
      end
    end else if (state_q == ST_MOVE && busDone) begin
      work_q[CNT_LSB +: CNT_W] <= workCnt - CNT_ONE;
      beats_q                  <= beats_q + CNT_ONE;
      if (finish) begin
        work_q[MODE_LSB +: MODE_W] <= MODE_STOP;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chanDone_q <= '0;
    end else begin
      chanDone_q <= hwClr;
    end
  end

  // ==========================================================================
  // Memory port sharing and register reads.
  assign swDescRd   = regRd && isDesc(regAddr);
  assign swDescWr   = regWr && isDesc(regAddr);
  assign regDescIdx = regAddr[DESC_IDX_W+1:2];

  assign descIf.rdAddr = swDescRd ? regDescIdx : {winCh, attr_q[ATTR_ALT][winCh]};
  assign descIf.wrEn   = swDescWr || (state_q == ST_WB);
  assign descIf.wrAddr = swDescWr ? regDescIdx : {chan_q, alt_q};
  assign descIf.wrData = swDescWr ? regWrData[DESC_W-1:0] : work_q;

  always_comb begin
    case (regAddr)
      REG_ENA_SET:  rdNext = DATA_W'(enable_q);
      REG_ATTR_GET: rdNext = DATA_W'(attrFlags);
      REG_PERIPH:   rdNext = DATA_W'(periphSel_q);
      REG_SWREQ:    rdNext = DATA_W'(swReq_q);
      default:      rdNext = '0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdReg_q <= '0;
      rdMem_q <= 1'b0;
    end else begin
      rdMem_q <= swDescRd;
      rdReg_q <= regRd ? rdNext : '0;
    end
  end

  assign regRdData    = rdMem_q ? DATA_W'(descIf.rdData) : rdReg_q;
  assign busReq       = (state_q == ST_MOVE);
  assign busChan      = chan_q;
  assign busAltStruct = alt_q;
  assign busItemSize  = work_q[SIZE_LSB +: STEP_W];
  assign busSrcStep   = work_q[SRC_LSB +: STEP_W];
  assign busDstStep   = work_q[DST_LSB +: STEP_W];
  assign chanDone     = chanDone_q;

  // ==========================================================================
  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_moveNeedsEnable;
    (state_q == ST_FETCH && state_d == ST_MOVE) |-> enable_q[chan_q];
  endproperty
  a_moveNeedsEnable: assert property (p_moveNeedsEnable) else $error("moved while disabled");

  property p_autoClear;
    (finish && !swSet[chan_q]) |=> !enable_q[$past(chan_q)] && chanDone != '0;
  endproperty
  a_autoClear: assert property (p_autoClear) else $error("enable kept after done");

  property p_grantEnabled;
    grant |-> enable_q[winCh] ##1 state_q == ST_FETCH;
  endproperty
  a_grantEnabled: assert property (p_grantEnabled) else $error("disabled channel won");

  property p_enaRead;
    hit(regRd, regAddr, REG_ENA_SET) |=> regRdData[NUM_CH-1:0] == $past(enable_q);
  endproperty
  a_enaRead: assert property (p_enaRead) else $error("enable readback wrong");

  property p_burstOnly;
    (grant && attr_q[ATTR_BURST][winCh] && !swReq_q[winCh] && !autoRun_q[winCh])
      |-> burstSel[winCh];
  endproperty
  a_burstOnly: assert property (p_burstOnly) else $error("single served on burst-only");

  property p_priority;
    (grant && hiElig != '0) |-> attr_q[ATTR_PRIO][winCh];
  endproperty
  a_priority: assert property (p_priority) else $error("normal channel beat high");

  property p_mask;
    (grant && attr_q[ATTR_MASK][winCh]) |-> (swReq_q[winCh] || autoRun_q[winCh]);
  endproperty
  a_mask: assert property (p_mask) else $error("masked request served");

  property p_arbBound;
    (state_q == ST_MOVE) |-> beats_q < arbLimit;
  endproperty
  a_arbBound: assert property (p_arbBound) else $error("tenure overran arbitration size");

  property p_countDown;
    (state_q == ST_MOVE && busDone) |=> workCnt == $past(workCnt) - CNT_ONE;
  endproperty
  a_countDown: assert property (p_countDown) else $error("count not decremented");

  property p_stopMode;
    finish |=> state_q == ST_WB && work_q[MODE_LSB +: MODE_W] == MODE_STOP;
  endproperty
  a_stopMode: assert property (p_stopMode) else $error("mode not stopped at end");

  c_finish:  cover property (state_q == ST_MOVE && finish);
  c_hiWin:   cover property (grant && hiElig != '0 && (eligible & ~hiElig) != '0);
  c_autoRun: cover property (state_q == ST_WB && run_q && !finish ##[1:20] grant);

endmodule

// ===== sim/dcc_bus_model.sv
`timescale 1ns/1ps
// ============================================================================
// Memory side of the engine: ends each item access after a set wait.
module dcc_bus_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        busReq,
  input  wire logic [3:0]  waitCycles,
  output logic             busDone,
  output logic      [15:0] itemCnt
);
  logic [3:0] waitQ;

  // One done pulse per item; a slow setting lets aborts land mid-tenure.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      waitQ   <= 4'h0;
      busDone <= 1'b0;
      itemCnt <= 16'h0000;
    end else begin
      busDone <= 1'b0;
      if (!busReq || busDone) begin
        waitQ <= 4'h0;
      end else if (waitQ >= waitCycles) begin
        busDone <= 1'b1;
        waitQ   <= 4'h0;
        itemCnt <= itemCnt + 16'h0001;
      end else begin
        waitQ <= waitQ + 4'h1;
      end
    end
  end
endmodule

// ===== sim/dcc_channel_ctrl_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %0h want %0h", $time, g, e); end end
module dcc_channel_ctrl_tb;
  import dcc_pkg::*;
  // ==========================================================================
  // Signals.
  logic              clk          = 1'b0;
  logic              rst_b        = 1'b0;
  logic [ADDR_W-1:0] regAddr      = 8'h00;
  logic [DATA_W-1:0] regWrData    = 32'h0000_0000;
  logic              regWr        = 1'b0;
  logic              regRd        = 1'b0;
  logic [NUM_CH-1:0] pSgl         = 4'h0;
  logic [NUM_CH-1:0] pBst         = 4'h0;
  logic [NUM_CH-1:0] sSgl         = 4'h0;
  logic [NUM_CH-1:0] sBst         = 4'h0;
  logic [3:0]        waitCycles   = 4'h0;
  logic              reqQ         = 1'b0;
  logic [DATA_W-1:0] regRdData;
  logic              busReq;
  logic              busDone;
  logic [CH_W-1:0]   busChan;
  logic              busAltStruct;
  logic [STEP_W-1:0] busItemSize;
  logic [STEP_W-1:0] busSrcStep;
  logic [STEP_W-1:0] busDstStep;
  logic [NUM_CH-1:0] chanDone;
  logic [15:0]       itemCnt;
  logic [15:0]       base;
  logic [CH_W-1:0]   firstChan;
  logic [DATA_W-1:0] rdv;
  int                failures     = 0;
  int                total_checks = 0;
  int                tenures      = 0;

  dcc_channel_ctrl DUT (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .priSingleReq(pSgl),
    .priBurstReq(pBst), .secSingleReq(sSgl), .secBurstReq(sBst), .busReq(busReq),
    .busDone(busDone), .busChan(busChan), .busAltStruct(busAltStruct),
    .busItemSize(busItemSize), .busSrcStep(busSrcStep), .busDstStep(busDstStep),
    .chanDone(chanDone));
  dcc_bus_model mem (.clk(clk), .rst_b(rst_b), .busReq(busReq), .waitCycles(waitCycles),
    .busDone(busDone), .itemCnt(itemCnt));

  // A 25 MHz clock.
  always #20 clk = ~clk;

  // Counting tenures tells how many items each grant moved before re-arbitration.
  always @(posedge clk) begin
    if (busReq === 1'b1 && reqQ === 1'b0) begin
      if (tenures == 0) begin
        firstChan = busChan;
      end
      tenures++;
    end
    reqQ = busReq;
  end

  // ==========================================================================
  // Helpers.
  function automatic logic [ADDR_W-1:0] aA(input int a, input logic clr);
    return REG_ATTR_BASE + 8'(a) * REG_ATTR_STEP + (clr ? REG_CLR_OFS : 8'h00);
  endfunction
  function automatic logic [ADDR_W-1:0] dA(input int ch, input int alt);
    return REG_DESC_BASE + 8'(8 * ch + 4 * alt);
  endfunction
  function automatic logic [DATA_W-1:0] dw(input logic [1:0] sz, input logic [1:0] sr,
      input logic [1:0] ds, input logic [3:0] arb, input logic [2:0] md, input logic [10:0] n);
    return {5'h00, n, 2'h0, md, 1'b0, arb, ds, sr, sz};
  endfunction
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWr     <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 rdv = regRdData;
    @(posedge clk);
  endtask
  // Waits on a completion pulse (0), an item total (1) or a bus request (2), never forever.
  task automatic waitOn(input int sel, input int x);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (!(sel == 0 ? chanDone[x] === 1'b1 : sel == 1 ? int'(itemCnt) >= x :
                 busReq === 1'b1) && n < 400);
    if (n >= 400) begin
      failures++;
      $display("[ERR] %0t wait %0d timed out", $time, sel);
      test_done();
    end
    @(posedge clk);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_regs();
    rd(REG_ENA_SET);
    `CHK(rdv, 32'h0000_0000)
    for (int a = 0; a < ATTR_NUM; a++) wr(aA(a, 1'b0), 32'(1) << a);
    rd(REG_ATTR_GET);
    `CHK(rdv, 32'h0000_8421)
    wr(aA(ATTR_ALT, 1'b1), 32'h0000_0002);
    rd(REG_ATTR_GET);
    `CHK(rdv, 32'h0000_8401)
    for (int a = 0; a < ATTR_NUM; a++) wr(aA(a, 1'b1), 32'h0000_000F);
    rd(REG_ATTR_GET);
    `CHK(rdv, 32'h0000_0000)
    for (int i = 0; i < 3; i++) begin
      wr(dA(3, 0), dw(2'(i), 2'(i), DST_STEP_NONE, 4'(i), MODE_BASIC, 11'h7FF));
      wr(dA(3, 1), dw(SIZE_8, SRC_STEP_NONE, 2'(i), ARB_SIZE_MAX, MODE_AUTO, 11'(i)));
      rd(dA(3, 0));
      `CHK(rdv, dw(2'(i), 2'(i), DST_STEP_NONE, 4'(i), MODE_BASIC, 11'h7FF))
      rd(dA(3, 1));
      `CHK(rdv, dw(SIZE_8, SRC_STEP_NONE, 2'(i), ARB_SIZE_MAX, MODE_AUTO, 11'(i)))
    end
    $display("register test done");
  endtask

  task automatic t_gate();
    wr(dA(0, 0), dw(SIZE_8, SIZE_8, SIZE_8, 4'h0, MODE_BASIC, 11'h002));
    base    = itemCnt;
    tenures = 0;
    pBst[0] <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(tenures, 0)
    wr(REG_ENA_SET, 32'h0000_0001);
    waitOn(0, 0);
    `CHK(itemCnt - base, 16'h0002)
    `CHK(tenures, 2)
    rd(REG_ENA_SET);
    `CHK(rdv[0], 1'b0)
    repeat (20) @(posedge clk);
    `CHK(tenures, 2)
    pBst[0] <= 1'b0;
    $display("enable test done");
  endtask

  task automatic t_auto();
    waitCycles <= 4'h4;
    wr(dA(1, 0), dw(SIZE_32, SIZE_32, DST_STEP_NONE, 4'h1, MODE_AUTO, 11'h005));
    wr(REG_ENA_SET, 32'h0000_0002);
    base    = itemCnt;
    tenures = 0;
    pSgl[1] <= 1'b1;
    @(posedge clk);
    pSgl[1] <= 1'b0;
    waitOn(2, 0);
    `CHK({busChan, busAltStruct}, 3'h2)
    `CHK(busItemSize, SIZE_32)
    `CHK(busSrcStep, SIZE_32)
    `CHK(busDstStep, DST_STEP_NONE)
    waitOn(0, 1);
    `CHK(itemCnt - base, 16'h0005)
    `CHK(tenures, 3)
    rd(dA(1, 0));
    `CHK(rdv[26:16], CNT_ZERO)
    `CHK(rdv[13:11], MODE_STOP)
    waitCycles <= 4'h0;
    $display("auto test done");
  endtask

  task automatic t_attrs();
    wr(aA(ATTR_BURST, 1'b0), 32'h0000_0004);
    wr(aA(ATTR_MASK, 1'b0), 32'h0000_0008);
    wr(aA(ATTR_ALT, 1'b0), 32'h0000_0001);
    wr(dA(0, 1), dw(SIZE_16, SIZE_16, SIZE_16, 4'h0, MODE_AUTO, 11'h001));
    for (int c = 2; c < 4; c++) wr(dA(c, 0), dw(SIZE_8, SIZE_8, SIZE_8, 4'h0, MODE_AUTO, 11'h001));
    wr(REG_ENA_SET, 32'h0000_000C);
    tenures = 0;
    pSgl[2] <= 1'b1;
    pBst[3] <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(tenures, 0)
    pSgl[2] <= 1'b0;
    pBst[3] <= 1'b0;
    pBst[2] <= 1'b1;
    waitOn(0, 2);
    pBst[2] <= 1'b0;
    wr(REG_SWREQ, 32'h0000_0008);
    waitOn(0, 3);
    wr(REG_ENA_SET, 32'h0000_0001);
    pSgl[0] <= 1'b1;
    waitOn(2, 0);
    `CHK(busAltStruct, 1'b1)
    waitOn(0, 0);
    pSgl[0] <= 1'b0;
    for (int a = 0; a < ATTR_NUM; a++) wr(aA(a, 1'b1), 32'h0000_000F);
    $display("attribute test done");
  endtask

  task automatic t_prio();
    wr(aA(ATTR_PRIO, 1'b0), 32'h0000_0008);
    for (int c = 2; c < 4; c++) wr(dA(c, 0), dw(SIZE_8, SIZE_8, SIZE_8, 4'h0, MODE_AUTO, 11'h001));
    pBst[3:2] <= 2'b11;
    tenures = 0;
    wr(REG_ENA_SET, 32'h0000_000C);
    waitOn(0, 3);
    `CHK(firstChan, 2'h3)
    waitOn(0, 2);
    pBst[3:2] <= 2'b00;
    wr(aA(ATTR_PRIO, 1'b1), 32'h0000_0008);
    wr(REG_PERIPH, 32'h0000_0001);
    wr(dA(0, 0), dw(SIZE_8, SIZE_8, SIZE_8, 4'h0, MODE_AUTO, 11'h001));
    wr(REG_ENA_SET, 32'h0000_0001);
    tenures = 0;
    pBst[0] <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(tenures, 0)
    pBst[0] <= 1'b0;
    sBst[0] <= 1'b1;
    waitOn(0, 0);
    sBst[0] <= 1'b0;
    wr(REG_PERIPH, 32'h0000_0000);
    $display("priority test done");
  endtask

  task automatic t_basic();
    waitCycles <= 4'h3;
    wr(dA(0, 0), dw(SIZE_8, SIZE_8, SIZE_8, 4'h0, MODE_BASIC, 11'h008));
    wr(REG_ENA_SET, 32'h0000_0001);
    pBst[0] <= 1'b1;
    waitOn(1, int'(itemCnt) + 2);
    pBst[0] <= 1'b0;
    repeat (20) @(posedge clk);
    base = itemCnt;
    repeat (20) @(posedge clk);
    `CHK(itemCnt, base)
    rd(REG_ENA_SET);
    `CHK(rdv[0], 1'b1)
    pBst[0] <= 1'b1;
    waitOn(1, int'(base) + 1);
    wr(REG_ENA_CLR, 32'h0000_0001);
    repeat (20) @(posedge clk);
    base = itemCnt;
    repeat (20) @(posedge clk);
    `CHK(itemCnt, base)
    rd(REG_ENA_SET);
    `CHK(rdv[0], 1'b0)
    pBst[0] <= 1'b0;
    wr(dA(0, 0), dw(SIZE_8, SIZE_8, SIZE_8, 4'h1, MODE_BASIC, 11'h001) | 32'h0000_0400);
    wr(REG_ENA_SET, 32'h0000_0001);
    pSgl[0] <= 1'b1;
    repeat (20) @(posedge clk);
    `CHK(itemCnt, base)
    {pBst[0], pSgl[0]} <= 2'b10;
    waitOn(0, 0);
    pBst[0] <= 1'b0;
    $display("basic test done");
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_regs();
    t_gate();
    t_auto();
    t_attrs();
    t_prio();
    t_basic();
    test_done();
  end
endmodule
